// >>> logic/lpf_freeze_ctrl.sv
// Purpose: entry and exit sequencing of the static low-power freeze mode
// Assumes: pad and config inputs synchronous to core_clk, request and consent synchronised here; mode_type2 static after reset
// Notes: outputs model pll power, clock gating, input forcing, pad freeze
`timescale 1ns/10ps
module lpf_freeze_ctrl
  import lpf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic mode_type2_cfg,
  input wire logic freeze_request_pin,
  input wire logic core_freeze_consent,
  input wire logic [lpf_pkg::IN_W-1:0] input_hold_cfg,
  input wire logic [lpf_pkg::IN_W-1:0] pad_in,
  input wire logic [lpf_pkg::IN_W-1:0] pad_in_held,
  output logic freeze_active,
  output logic pll_power_down,
  output logic pll_clk_enable,
  output logic pad_freeze,
  output logic [lpf_pkg::IN_W-1:0] core_in
);
  import lpf_pkg::*;

  logic req_clean;
  logic consent_clean;
  logic type2_reg;
  logic cfg_taken_reg;
  logic type2_next;
  logic cfg_taken_next;
  lpf_state_t state_reg;
  lpf_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic frozen_reg;
  logic frozen_next;
  logic [IN_W-1:0] core_in_reg;
  logic [IN_W-1:0] core_in_next;
  logic enter_cond;

  lpf_input_filter u_req_filt (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .raw_in(freeze_request_pin),
    .clean_out(req_clean)
  );

  lpf_input_filter u_consent_filt (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .raw_in(core_freeze_consent),
    .clean_out(consent_clean)
  );

  always_comb
  begin
    type2_next = type2_reg;
    cfg_taken_next = cfg_taken_reg;
    if (!cfg_taken_reg)
    begin
      type2_next = mode_type2_cfg;
      cfg_taken_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      type2_reg <= 1'b0;
      cfg_taken_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      type2_reg <= type2_next;
      cfg_taken_reg <= cfg_taken_next;
    end
  end

  assign enter_cond = req_clean && (!type2_reg || consent_clean);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    frozen_next = frozen_reg;
    case (state_reg)
      ST_POWERUP:
      begin
        // settle window for a request held through power-up
        if (cfg_taken_reg && enter_cond)
        begin
          state_next = ST_ENTERING;
          cnt_next = ENTRY_DELAY;
        end
        else if (cnt_reg == CNT_W'(POWERUP_CYC - 1))
        begin
          state_next = ST_RUN;
        end
        else
        begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      ST_RUN:
      begin
        if (enter_cond)
        begin
          state_next = ST_ENTERING;
          cnt_next = ENTRY_DELAY;
        end
      end
      ST_ENTERING:
      begin
        // dropping the request, or in type 2 the consent, aborts entry
        if (!enter_cond)
        begin
          state_next = ST_RUN;
        end
        else if (cnt_reg == CNT_RST)
        begin
          state_next = ST_FROZEN;
          frozen_next = 1'b1;
        end
        else
        begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      ST_FROZEN:
      begin
        if (!req_clean)
        begin
          state_next = ST_EXITING;
          cnt_next = EXIT_DELAY;
        end
      end
      ST_EXITING:
      begin
        // a pin raised again here waits until exit has completed
        if (cnt_reg == CNT_RST)
        begin
          state_next = ST_RUN;
          frozen_next = 1'b0;
        end
        else
        begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default:
      begin
        state_next = ST_RUN;
        frozen_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_POWERUP;
      cnt_reg <= CNT_RST;
      frozen_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      frozen_reg <= frozen_next;
    end
  end

  always_comb
  begin
    core_in_next = pad_in;
    if (frozen_next)
    begin
      core_in_next = (IN_ALL_HIGH & ~input_hold_cfg) |
                     (pad_in_held & input_hold_cfg);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      core_in_reg <= '0;
    end
    else if (clk_en)
    begin
      core_in_reg <= core_in_next;
    end
  end

  // clock stop and pad freeze same cycle
  // one registered edge here; real silicon skews it
  assign freeze_active = frozen_reg;
  assign pll_power_down = frozen_reg;
  assign pll_clk_enable = !frozen_reg;
  assign pad_freeze = frozen_reg;
  assign core_in = core_in_reg;
endmodule

// >>> logic/lpf_pkg.sv
// Purpose: constants and types for the low-power freeze controller
// Assumes: core_clk at 20 MHz
// Notes: times kept in ns, cycle counts derived from the clock period
package lpf_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ENTRY_MAX_NS = 1000;
  localparam int EXIT_MAX_NS = 1000;
  localparam int POWERUP_MAX_NS = 5000;
  // longest times round down to whole cycles
  localparam int ENTRY_CYC = ENTRY_MAX_NS / CLK_PERIOD_NS;
  localparam int EXIT_CYC = EXIT_MAX_NS / CLK_PERIOD_NS;
  localparam int POWERUP_CYC = POWERUP_MAX_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  localparam int FILT_LEN = 3;
  localparam int CNT_W = 8;
  localparam int IN_W = 8;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  // the pin may change just after an edge and is first sampled one edge
  // later, so that cycle is taken off too to keep the limit from the pin
  localparam logic [CNT_W-1:0] ENTRY_DELAY =
    CNT_W'(ENTRY_CYC - SYNC_STAGES - FILT_LEN - 3);
  localparam logic [CNT_W-1:0] EXIT_DELAY =
    CNT_W'(EXIT_CYC - SYNC_STAGES - FILT_LEN - 3);
  localparam logic [IN_W-1:0] IN_ALL_HIGH = 8'hff;

  typedef enum logic [2:0] {
    ST_POWERUP  = 3'b000,
    ST_RUN      = 3'b001,
    ST_ENTERING = 3'b010,
    ST_FROZEN   = 3'b011,
    ST_EXITING  = 3'b100
  } lpf_state_t;
endpackage

// >>> logic/lpf_input_filter.sv
// Purpose: two-flop synchroniser followed by a stable-level filter
// Assumes: input may bounce; output changes only after FILT_LEN equal samples
// Notes: first flop feeds only the second flop
`timescale 1ns/10ps
module lpf_input_filter
  import lpf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic raw_in,
  output logic clean_out
);
  import lpf_pkg::*;
  logic meta_reg;
  logic sync_reg;
  logic [FILT_LEN-1:0] hist_reg;
  logic clean_reg;
  logic [FILT_LEN-1:0] hist_next;
  logic clean_next;

  always_comb
  begin
    hist_next = {hist_reg[FILT_LEN-2:0], sync_reg};
    clean_next = clean_reg;
    if (&hist_reg)
    begin
      clean_next = 1'b1;
    end
    else if (~|hist_reg)
    begin
      clean_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      hist_reg <= '0;
      clean_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      hist_reg <= hist_next;
      clean_reg <= clean_next;
    end
  end

  assign clean_out = clean_reg;
endmodule

// >>> test/lpf_chk_sva.sv
// Purpose: port timing checks of the freeze controller
// Assumes: type strap static between resets
// Notes: counters track how long a request has been held and how long the pin has been low
`timescale 1ns/10ps
module lpf_chk
  import lpf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mode_type2_cfg,
  input wire logic freeze_request_pin,
  input wire logic core_freeze_consent,
  input wire logic [lpf_pkg::IN_W-1:0] input_hold_cfg,
  input wire logic [lpf_pkg::IN_W-1:0] pad_in,
  input wire logic [lpf_pkg::IN_W-1:0] pad_in_held,
  input wire logic freeze_active,
  input wire logic pll_power_down,
  input wire logic pll_clk_enable,
  input wire logic pad_freeze,
  input wire logic [lpf_pkg::IN_W-1:0] core_in
);
  logic on_c;
  logic [6:0] on_reg, on_next;
  logic [4:0] off_reg, off_next;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  assign on_c = freeze_request_pin & (~mode_type2_cfg | core_freeze_consent);
  // a request outside reset starts at 80, so 100 marks 20 cycles of pin
  always_comb
  begin
    on_next = on_c ? on_reg + {6'h0, ~&on_reg} : 7'h50;
    off_next = freeze_request_pin ? 5'h0 : off_reg + {4'h0, ~&off_reg};
  end
  always_ff @(posedge core_clk)
  begin
    on_reg <= rst ? 7'h0 : on_next;
    off_reg <= rst ? 5'h0 : off_next;
  end
  chk_pll_off: assert property (pll_power_down == freeze_active)
    else $error("pll power down not tied to freeze");
  chk_clk_gate: assert property (pll_clk_enable != freeze_active)
    else $error("pll clock enable wrong");
  chk_pad_hold: assert property (pad_freeze == freeze_active)
    else $error("pads not frozen with the clocks");
  chk_entry_time: assert property
    (on_reg >= 7'h64 |-> freeze_active)
    else $error("freeze entry late");
  chk_entry_cause: assert property
    ($rose(freeze_active) |-> $past(on_c))
    else $error("freeze without its request");
  chk_exit_time: assert property (off_reg >= 5'h14 |-> !freeze_active)
    else $error("freeze exit late");
  chk_frozen_stays: assert property
    (freeze_active && freeze_request_pin |=> freeze_active)
    else $error("freeze left while pin held");
  chk_force_high: assert property (freeze_active |-> core_in ==
    $past(~input_hold_cfg | (input_hold_cfg & pad_in_held)))
    else $error("frozen inputs not forced");
  chk_low_rises: assert property ($rose(freeze_active) &&
    !$past(pad_in[7]) && !input_hold_cfg[7] |-> $rose(core_in[7]))
    else $error("low input did not rise");
  chk_pass_thru: assert property (!freeze_active &&
    !$past(freeze_active) && !$past(rst) |-> core_in == $past(pad_in))
    else $error("inputs not passed when running");
  cover property ($rose(freeze_active));
  cover property ($fell(freeze_active));
  cover property (freeze_active && mode_type2_cfg);
endmodule
bind lpf_freeze_ctrl lpf_chk u_chk (.core_clk, .rst, .mode_type2_cfg,
  .freeze_request_pin, .core_freeze_consent, .input_hold_cfg, .pad_in,
  .pad_in_held, .freeze_active, .pll_power_down, .pll_clk_enable,
  .pad_freeze, .core_in);

// >>> test/lpf_far_end.sv
// Purpose: controller and user logic that request freeze
// Assumes: bench sets want_pin and want_ok
// Notes: dropping want_ok mid entry and a one-cycle pulse of want_pin are the misuses offered
`timescale 1ns/10ps
module lpf_far_end
(
  input wire logic core_clk,
  input wire logic want_pin,
  input wire logic want_ok,
  input wire logic frozen,
  output logic freeze_request_pin = 1'b0,
  output logic core_freeze_consent = 1'b0
);
  always @(posedge core_clk)
  begin
    freeze_request_pin <= want_pin;
    // consent kept until freeze is left
    core_freeze_consent <= want_ok | (core_freeze_consent & frozen);
  end
endmodule

// >>> test/low_power_freeze_control_test.sv
// Purpose: scenario bench for the freeze controller
// Assumes: fixed pad values, clk_en always high
// Notes: entry waits carry one cycle of slack over the 20 cycle limits, exit waits two
`timescale 1ns/10ps
module low_power_freeze_control_test;
  import lpf_pkg::*;
  logic core_clk = 1'b0;
  logic rst, mode_t2, want_pin, want_ok, fz, pd, ce, pf, frp, cons;
  logic [IN_W-1:0] ci;
  int fail_count = 0;
  int n_tests = 0;
  lpf_freeze_ctrl dut (.core_clk, .rst, .clk_en(1'b1),
    .mode_type2_cfg(mode_t2), .freeze_request_pin(frp),
    .core_freeze_consent(cons), .input_hold_cfg(8'h03), .pad_in(8'h5a),
    .pad_in_held(8'h0d), .freeze_active(fz), .pll_power_down(pd),
    .pll_clk_enable(ce), .pad_freeze(pf), .core_in(ci));
  lpf_far_end far (.core_clk, .want_pin, .want_ok, .frozen(fz),
    .freeze_request_pin(frp), .core_freeze_consent(cons));
  initial forever #25 core_clk = ~core_clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t freeze output mismatch", $time);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task rs(input logic t2);
    @(posedge core_clk) mode_t2 <= t2;
    rst <= 1'b1;
    wt(11);
    @(posedge core_clk) rst <= 1'b0;
  endtask
  task t_exit;
    @(posedge core_clk) want_pin <= 1'b0;
    wt(23);
    chk(fz, 8'h00);
    chk(ci, 8'h5a);
  endtask
  task t_powerup;
    rs(1'b0);
    wt(101);
    chk({fz, pd, ce, pf}, 8'h0d);
    chk(ci, 8'hfd);
    t_exit;
  endtask
  task t_type1;
    @(posedge core_clk) want_pin <= 1'b1;
    wt(22);
    chk({fz, ce}, 8'h02);
    t_exit;
    @(posedge core_clk) want_pin <= 1'b1;
    @(posedge core_clk) want_pin <= 1'b0;
    wt(30);
    chk(fz, 8'h00);
  endtask
  task t_type2;
    rs(1'b1);
    @(posedge core_clk) want_pin <= 1'b1;
    wt(30);
    chk(fz, 8'h00);
    @(posedge core_clk) want_ok <= 1'b1;
    wt(22);
    chk(fz, 8'h01);
    @(posedge core_clk) want_ok <= 1'b0;
    t_exit;
    @(posedge core_clk) want_ok <= 1'b1;
    want_pin <= 1'b1;
    wt(9);
    @(posedge core_clk) want_ok <= 1'b0;
    wt(30);
    chk(fz, 8'h00);
  endtask
  task close_out;
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    mode_t2 = 1'b0;
    want_pin = 1'b1;
    want_ok = 1'b0;
    t_powerup;
    t_type1;
    t_type2;
    close_out;
  end
  initial
  begin
    #100000;
    fail_count++;
    close_out;
  end
endmodule
